// >>> spe_pulse_encoder.v
`include "spe_regs.vh"
module spe_pulse_encoder (
   // clock and reset
   input wire ref_clk_in,
   input wire rst_in,
   // processed signal
   input wire [11:0] sample_in,
   input wire [11:0] peak_in,
   input wire [11:0] valley_in,
   // direction decision for the cycle, sampled on the rising event
   input wire [1:0] direction_in,
   // width option strap
   input wire [1:0] variant_in,
   // current loop and status
   output reg high_current_out,
   output reg fast_mode_out,
   output reg calibrated_out
);
   // sequencer states, one-hot
   localparam S_IDLE = 3'b001;
   localparam S_PRE = 3'b010;
   localparam S_PULSE = 3'b100;
   // pulse lengths in clock cycles, sized to the timer so no bits are dropped
   localparam [17:0] FWD_CYC = `SPE_CYC(`SPE_FWD_US);
   localparam [17:0] REV_NARROW_CYC = `SPE_CYC(`SPE_REV_NARROW_US);
   localparam [17:0] ND_NARROW_CYC = `SPE_CYC(`SPE_ND_NARROW_US);
   localparam [17:0] REV_WIDE_CYC = `SPE_CYC(`SPE_REV_WIDE_US);
   localparam [17:0] ND_WIDE_CYC = `SPE_CYC(`SPE_ND_WIDE_US);
   localparam [17:0] FWD_INT_CYC = `SPE_CYC(`SPE_FWD_INT_US);
   localparam [17:0] REV_INT_CYC = `SPE_CYC(`SPE_REV_INT_US);
   localparam [17:0] ND_INT_CYC = `SPE_CYC(`SPE_ND_INT_US);
   localparam [17:0] HS_CYC = `SPE_CYC(`SPE_HS_US);
   // timer load for the pre-low; the timer counts down to zero inclusive
   localparam [17:0] PRE_LAST = `SPE_CYC(`SPE_PRE_US) - 1;
   // mode limits as periods; a shorter period is a faster target
   localparam [19:0] ENTER_CYC = `SPE_ENTER_PERIOD;
   localparam [19:0] EXIT_CYC = `SPE_EXIT_PERIOD;
   // repeat count at which calibration completes
   localparam [2:0] CAL_LAST = `SPE_CAL_CYCLES - 1;
   wire rise_ev;
   reg [2:0] state_reg;
   reg [17:0] timer_reg;
   reg [17:0] width_reg;
   reg [19:0] period_reg;
   reg [2:0] cal_reg;
   reg [1:0] last_dir_reg;
   reg [1:0] variant_reg;
   // a pulse only starts from a rise seen after calibration
   wire start_ev = rise_ev && calibrated_out;
   // direction repeated from the previous cycle, undetermined excluded
   wire same_dir = (direction_in == last_dir_reg) && (direction_in != `SPE_DIR_ND);

   // width in cycles for a variant, direction and speed mode
   function [17:0] pick_width;
      input [1:0] var_sel;
      input [1:0] dir;
      input fast;
      begin
         pick_width = 18'd0;
         case (var_sel)
            // narrow and wide options ignore the speed mode
            `SPE_VAR_NARROW: begin // see RL2
               case (dir)
                  `SPE_DIR_FWD: pick_width = FWD_CYC;
                  `SPE_DIR_REV: pick_width = REV_NARROW_CYC;
                  default: pick_width = ND_NARROW_CYC;
               endcase
            end
            `SPE_VAR_WIDE: begin // see RL3
               case (dir)
                  `SPE_DIR_FWD: pick_width = FWD_CYC;
                  `SPE_DIR_REV: pick_width = REV_WIDE_CYC;
                  default: pick_width = ND_WIDE_CYC;
               endcase
            end
            // intermediate: one short width when fast, direction widths when slow
            default: begin
               if (fast) begin
                  pick_width = HS_CYC; // see RL7, RL8
               end else begin
                  case (dir) // see RL4
                     `SPE_DIR_FWD: pick_width = FWD_INT_CYC;
                     `SPE_DIR_REV: pick_width = REV_INT_CYC;
                     default: pick_width = ND_INT_CYC;
                  endcase
               end
            end
         endcase
      end
   endfunction

   // speed mode for a cycle of the given period; between the two limits it is kept
   function fast_decide;
      input [19:0] period;
      input fast_now;
      input [1:0] var_sel;
      begin
         fast_decide = 1'b0;
         if (var_sel == `SPE_VAR_INTER) begin
            if (period < ENTER_CYC) begin
               fast_decide = 1'b1; // see RL5
            end else if (period > EXIT_CYC) begin
               fast_decide = 1'b0; // see RL6
            end else begin
               fast_decide = fast_now; // see RL6
            end
         end
      end
   endfunction

   // threshold comparator; only the rising event paces the output
   spe_switch_detect u_detect (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .sample_in(sample_in),
      .peak_in(peak_in),
      .valley_in(valley_in),
      .rise_out(rise_ev),
      .fall_out()
   );

   // strap captured while reset is held, kept afterwards
   // a strap change needs a reset, so the width table never switches mid-pulse
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         variant_reg <= variant_in;
      end
   end

   // target-cycle period measured between rising events; saturates when slow
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         period_reg <= 20'hfffff;
         fast_mode_out <= 1'b0;
      end else if (rise_ev) begin
         period_reg <= 20'h00000;
         // same decision picks this cycle's width, so flag and pulse agree
         fast_mode_out <= fast_decide(period_reg, fast_mode_out, variant_reg); // see RL5, RL6
      end else if (period_reg != 20'hfffff) begin
         // saturation keeps a long stall from wrapping into a fast reading
         period_reg <= period_reg + 20'h00001;
         // a stalled target also counts as a falling rate
         if (period_reg > EXIT_CYC) begin
            fast_mode_out <= 1'b0; // see RL6
         end
      end
   end

   // calibration: count rising events of unchanged direction
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         cal_reg <= 3'h0;
         last_dir_reg <= `SPE_DIR_ND;
         calibrated_out <= 1'b0;
      end else if (rise_ev && !calibrated_out) begin
         last_dir_reg <= direction_in;
         // a changed or undetermined direction restarts the count
         if (same_dir) begin
            cal_reg <= cal_reg + 3'h1;
            if (cal_reg + 3'h1 >= CAL_LAST) begin
               calibrated_out <= 1'b1; // see RL10
            end
         end else begin
            cal_reg <= 3'h0;
         end
      end
   end

   // pulse sequencer: one pulse per rising event seen in idle once calibrated
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_reg <= S_IDLE;
         timer_reg <= 18'd0;
         width_reg <= 18'd0;
         high_current_out <= 1'b0;
      end else begin
         case (state_reg)
            S_IDLE: begin
               high_current_out <= 1'b0;
               if (start_ev) begin // see RL11
                  width_reg <= pick_width(variant_reg, direction_in,
                     fast_decide(period_reg, fast_mode_out, variant_reg));
                  // intermediate option waits out the pre-low first
                  if (variant_reg == `SPE_VAR_INTER) begin
                     timer_reg <= PRE_LAST; // see RL4
                     state_reg <= S_PRE;
                  end else begin
                     // other options raise the level on the next edge
                     timer_reg <= pick_width(variant_reg, direction_in, 1'b0) - 18'd1;
                     high_current_out <= 1'b1; // see RL1
                     state_reg <= S_PULSE;
                  end
               end
            end
            S_PRE: begin
               // low interval held before the high level
               if (timer_reg == 18'd0) begin
                  timer_reg <= width_reg - 18'd1;
                  high_current_out <= 1'b1; // see RL1
                  state_reg <= S_PULSE;
               end else begin
                  timer_reg <= timer_reg - 18'd1;
               end
            end
            S_PULSE: begin
               // a new cycle arriving mid-pulse is dropped; rate limits keep it rare
               if (timer_reg == 18'd0) begin
                  high_current_out <= 1'b0;
                  state_reg <= S_IDLE;
               end else begin
                  timer_reg <= timer_reg - 18'd1;
               end
            end
            // an illegal state code recovers to idle with the loop low
            default: begin
               state_reg <= S_IDLE;
               high_current_out <= 1'b0;
            end
         endcase
      end
   end
endmodule

// >>> spe_regs.vh
// Notes on behaviour
// RL1 - output is a current level select: high state at least 1.9 times low state
// RL2 - narrow variant: forward 45 us, reverse 90 us, undetermined 180 us pulses
// RL3 - wide variant: forward 45 us, reverse 180 us, undetermined 360 us pulses
// RL4 - intermediate slow: forward 60, reverse 120, undetermined 30 us, each after 30 us pre-low
// RL5 - intermediate enters high-speed mode when rising cycle rate exceeds 1.1 kHz
// RL6 - high-speed mode is left only when falling rate drops below 1 kHz
// RL7 - high-speed mode sends a fixed 30 us pulse per target cycle
// RL8 - no direction coding in high-speed mode; controller must not decode direction there
// RL9 - rising event at 70 percent of amplitude, falling event at 30 percent
// RL10 - first valid pulse after at most 4 (typically 3) constant-direction target cycles
// RL11 - exactly one pulse per detected target cycle, width from that cycle's direction; a rise during a pre-low or pulse is dropped
`ifndef SPE_REGS_VH
`define SPE_REGS_VH
`define SPE_CLK_MHZ 250
`define SPE_FWD_US 45
`define SPE_REV_NARROW_US 90
`define SPE_ND_NARROW_US 180
`define SPE_REV_WIDE_US 180
`define SPE_ND_WIDE_US 360
`define SPE_FWD_INT_US 60
`define SPE_REV_INT_US 120
`define SPE_ND_INT_US 30
`define SPE_HS_US 30
`define SPE_PRE_US 30
// cycle counts derived from the us figures at the clock rate
`define SPE_CYC(us) ((us) * `SPE_CLK_MHZ)
// period limits for the 1.1 kHz entry and 1 kHz exit, in clock cycles
`define SPE_ENTER_HZ 1100
`define SPE_EXIT_HZ 1000
`define SPE_ENTER_PERIOD ((`SPE_CLK_MHZ * 1000000) / `SPE_ENTER_HZ)
`define SPE_EXIT_PERIOD ((`SPE_CLK_MHZ * 1000000) / `SPE_EXIT_HZ)
// switch points in percent of amplitude
`define SPE_RISE_PCT 70
`define SPE_FALL_PCT 30
// calibration length in target cycles
`define SPE_CAL_CYCLES 3
// variant select codes
`define SPE_VAR_NARROW 2'h0
`define SPE_VAR_WIDE 2'h1
`define SPE_VAR_INTER 2'h2
// direction codes
`define SPE_DIR_FWD 2'h0
`define SPE_DIR_REV 2'h1
`define SPE_DIR_ND 2'h2
`endif

// >>> spe_switch_detect.v
`include "spe_regs.vh"
module spe_switch_detect (
   // clock and reset
   input wire ref_clk_in,
   input wire rst_in,
   // processed signal and its tracked extremes
   input wire [11:0] sample_in,
   input wire [11:0] peak_in,
   input wire [11:0] valley_in,
   // events
   output reg rise_out,
   output reg fall_out
);
   // percentages held at the threshold width so the products never wrap
   localparam [19:0] RISE_PCT = `SPE_RISE_PCT;
   localparam [19:0] FALL_PCT = `SPE_FALL_PCT;
   localparam [19:0] HUNDRED = 20'h00064;
   wire [11:0] span = peak_in - valley_in;
   wire [19:0] span_w = {8'h00, span};
   wire [19:0] rise_th = {8'h00, valley_in} + (span_w * RISE_PCT) / HUNDRED;
   wire [19:0] fall_th = {8'h00, valley_in} + (span_w * FALL_PCT) / HUNDRED;
   reg high_reg;
   // hysteretic comparator; the 70/30 gap rejects noise near the midpoint
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         high_reg <= 1'b0;
         rise_out <= 1'b0;
         fall_out <= 1'b0;
      end else begin
         rise_out <= 1'b0;
         fall_out <= 1'b0;
         if (!high_reg && {8'h00, sample_in} > rise_th) begin // see RL9
            high_reg <= 1'b1;
            rise_out <= 1'b1;
         end else if (high_reg && {8'h00, sample_in} < fall_th) begin // see RL9
            high_reg <= 1'b0;
            fall_out <= 1'b1;
         end
      end
   end
endmodule

// >>> spe_chk.sv
module spe_chk (
   // clock and reset
   input wire ref_clk_in,
   input wire rst_in,
   // strap and loop outputs
   input wire [1:0] variant_in,
   input wire high_current_out,
   input wire fast_mode_out,
   input wire calibrated_out
);
   logic [18:0] hi_c;
   logic [18:0] lo_c;
   // run lengths of each level; low saturates so long stalls stay measurable
   always @(posedge ref_clk_in) begin
      hi_c <= (rst_in || !high_current_out) ? 19'h0 : hi_c + 19'h1;
      lo_c <= (rst_in || high_current_out) ? 19'h0 : (lo_c[18] ? lo_c : lo_c + 19'h1);
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   chk_reset_idle: assert property ($fell(rst_in) |-> !high_current_out && !fast_mode_out && !calibrated_out)
      else $error("outputs not idle after reset");
   chk_no_early_pulse: assert property ($rose(high_current_out) |-> calibrated_out)
      else $error("pulse before calibration");
   chk_cal_holds: assert property (calibrated_out |=> calibrated_out)
      else $error("calibration lost");
   chk_fast_inter: assert property (fast_mode_out |-> variant_in == 2'h2)
      else $error("fast mode outside intermediate option");
   chk_narrow_width: assert property ($fell(high_current_out) && variant_in == 2'h0 |->
      hi_c == 19'h2bf2 || hi_c == 19'h57e4 || hi_c == 19'hafc8)
      else $error("narrow pulse width wrong");
   chk_wide_width: assert property ($fell(high_current_out) && variant_in == 2'h1 |->
      hi_c == 19'h2bf2 || hi_c == 19'hafc8 || hi_c == 19'h15f90)
      else $error("wide pulse width wrong");
   chk_inter_width: assert property ($fell(high_current_out) && variant_in == 2'h2 |->
      hi_c == 19'h3a98 || hi_c == 19'h7530 || hi_c == 19'h1d4c)
      else $error("intermediate pulse width wrong");
   chk_fast_width: assert property ($fell(high_current_out) && fast_mode_out |-> hi_c == 19'h1d4c)
      else $error("fast pulse width wrong");
   chk_pre_low: assert property ($rose(high_current_out) && variant_in == 2'h2 |-> lo_c >= 19'h1d4c)
      else $error("pre low interval too short");
   chk_fast_exit: assert property ($fell(fast_mode_out) |-> lo_c > 19'h38270)
      else $error("fast mode left too early");
endmodule
bind spe_pulse_encoder spe_chk u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .variant_in(variant_in),
   .high_current_out(high_current_out), .fast_mode_out(fast_mode_out), .calibrated_out(calibrated_out));

// >>> spe_ctl_model.sv
module spe_ctl_model (
   // clock and loop current
   input wire ref_clk_in,
   input wire high_current_in,
   // decoded pulse count and last width in cycles
   output logic [15:0] pulses_out,
   output logic [18:0] width_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [18:0] run_reg;
   logic prev_reg;
   initial begin
      pulses_out = 16'h0;
      width_out = 19'h0;
      run_reg = 19'h0;
      prev_reg = 1'b0;
   end
   // width only, no direction decoded, so fast pulses cannot mislead us
   always @(posedge ref_clk_in) begin
      prev_reg <= high_current_in;
      run_reg <= high_current_in ? run_reg + 19'h1 : 19'h0;
      if (prev_reg && !high_current_in) begin
         pulses_out <= pulses_out + 16'h1;
         width_out <= run_reg;
      end
   end
endmodule

// >>> speed_direction_pulse_encoder_bench.sv
module speed_direction_pulse_encoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] smp = 12'h100;
   logic [1:0] dir = 2'h0;
   logic [1:0] var_sel = 2'h0;
   wire hi;
   wire fast;
   wire cal;
   wire [15:0] np;
   wire [18:0] w;
   int n_fail = 0;
   int checks = 0;
   int per;
   logic [15:0] n0;
   // option, direction, width in us
   logic [19:0] rows [9] = '{20'h0002d, 20'h1005a, 20'h200b4, 20'h4002d, 20'h500b4, 20'h60168,
      20'h8003c, 20'h90078, 20'ha001e};
   always #2 clk = ~clk;
   spe_pulse_encoder u_dut (.ref_clk_in(clk), .rst_in(rst), .sample_in(smp), .peak_in(12'hfff),
      .valley_in(12'h000), .direction_in(dir), .variant_in(var_sel), .high_current_out(hi),
      .fast_mode_out(fast), .calibrated_out(cal));
   spe_ctl_model u_ctl (.ref_clk_in(clk), .high_current_in(hi), .pulses_out(np), .width_out(w));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("fails %0d checks %0d", n_fail, checks);
      if (n_fail == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one target cycle: above 70 percent, then below 30 percent
   task automatic tcyc(input logic [1:0] d, input int p);
      @(posedge clk) #1;
      dir = d;
      smp = 12'hf00;
      repeat (p / 2) @(posedge clk);
      #1 smp = 12'h100;
      repeat (p - p / 2) @(posedge clk);
   endtask
   // reset with a new strap; slower calibration cycles flush any fast entry
   task automatic restart(input logic [1:0] v, input int p);
      @(posedge clk) #1;
      rst = 1'b1;
      var_sel = v;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      @(posedge clk) #1;
      check({hi, fast, cal}, 32'h0);
      n0 = np;
      repeat (3) tcyc(2'h0, p + 20000);
      check(np - n0, 32'h0);
      check(cal, 32'h1);
      tcyc(2'h0, p + 20000);
      check(np - n0, 32'h1);
   endtask
   // slow intermediate cycles dominate the run, so the cut is generous
   initial begin
      #30ms;
      n_fail++;
      conclude;
   end
   initial begin
      repeat (16) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         per = rows[i][19:18] == 2'h0 ? 50000 : (rows[i][19:18] == 2'h1 ? 100000 : 240000);
         if (i % 3 == 0) restart(rows[i][19:18], per);
         n0 = np;
         tcyc(rows[i][17:16], per);
         check(np - n0, 32'h1);
         check(w, rows[i][15:0] * 250);
      end
      repeat (3) tcyc(2'h1, 100000);
      check({fast, w}, {1'b1, 19'h1d4c});
      // the second rise measures a period inside the hysteresis band
      repeat (2) tcyc(2'h0, 240000);
      check({fast, w}, {1'b1, 19'h1d4c});
      repeat (260000) @(posedge clk);
      check(fast, 32'h0);
      tcyc(2'h0, 240000);
      check(w, 32'h3a98);
      // swing to just under the rising point: no event, so no pulse
      n0 = np;
      @(posedge clk) #1;
      smp = 12'ha00;
      repeat (100) @(posedge clk);
      #1 smp = 12'h100;
      repeat (30000) @(posedge clk);
      check(np - n0, 32'h0);
      conclude;
   end
endmodule
